/* dcr_chain_latch.sv */
// Configuration RAM, driver chain sequencer, host datagram receiver and
// reference position latch with automatic stop.
// Assumes an APB master on pclk, a host serial link on its own clock and
// a motor position and microstep phase supplied by the ramp logic.
//
// What this block and its host do
// RULE1: Nonzero window around latched position suppresses automatic stop inside it.
// RULE2: Any write to the captured position register arms the latch, unless the armed latch captures in the same cycle.
// RULE3: Armed latch stores motor position on reference switch activation edge.
// RULE4: With stop enabled, an active reference switch halts the motor.
// RULE5: Memory holds 128 six-bit cells as 64 addresses of two words.
// RULE6: Memory data field is 24 bits; low twelve bits carry two words.
// RULE7: Datagram bit 31 low selects registers, high selects memory.
// RULE8: Datagram bit 30 splits memory into lower and upper 32 addresses.
// RULE9: Lower addresses hold words of next-motor flag and 5-bit code.
// RULE10: Chain transmission reads words from address zero, each picking one signal.
// RULE11: A word with next-motor flag set increments the driver index.
// RULE12: Index equal to last driver ends transmission and clears index.
// RULE13: Upper 32 addresses hold one microstep table shared by all motors.
// RULE14: Quarter table is mirrored into full wave plus a 90 degree companion.
// RULE15: The host sends each command as a 32-bit serial datagram.
// RULE16: Host re-arms the latch before seeking the opposite switch edge.
// RULE17: Host takes the midpoint of both edges and zeroes positions there; the bench host only moves there, without zeroing.
// RULE18: Memory reads return zero in the twelve unused upper data bits.
`timescale 1ns/1ps
`default_nettype none
`include "dcr_cfg.svh"
module dcr_chain_latch
   import dcr_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        host_sck,
   input  wire logic        host_csn,
   input  wire logic        host_serial_in,
   input  wire logic        ref_switch,
   input  wire logic [23:0] motor_position,
   input  wire logic [7:0]  ustep_phase,
   output logic             motor_stop,
   output logic             chain_sck,
   output logic             chain_sdo,
   output logic             chain_csn
);
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   // Absolute distance between two positions
   function automatic logic [23:0] pos_dist(input logic [23:0] a,
                                            input logic [23:0] b);
      pos_dist = (a >= b) ? (a - b) : (b - a);
   endfunction

   logic [5:0] ram_q [0:`DCR_RAM_CELLS-1];

   // Quadrant unfold of the quarter table; sign plus magnitude [RULE14]
   function automatic logic [6:0] wave(input logic [7:0] ph);
      logic [5:0] i;
      i = ph[6] ? (6'h3F - ph[5:0]) : ph[5:0];
      wave = {ph[7], ram_q[{1'b1, i}]}; // [RULE13]
   endfunction

   // ------------------------------------------------------------
   // Host link domain: datagram shift in
   // ------------------------------------------------------------
   logic [5:0]  lk_cnt_q;
   logic [31:0] lk_shift_q;
   logic [31:0] lk_word_q;
   logic        lk_tgl_q;
   logic        lk_clr;
   assign lk_clr = ~presetn | host_csn;

   // Counter cleared by the frame select, so no edge after the frame
   always_ff @(posedge host_sck or posedge lk_clr) begin
      if (lk_clr) begin
         lk_cnt_q <= 6'h00;
      end else if (lk_cnt_q != `DCR_DG_BITS) begin
         lk_cnt_q <= lk_cnt_q + 6'h01;
      end
   end

   // MSB first; the 32nd bit publishes the word and flips the toggle
   always_ff @(posedge host_sck or negedge presetn) begin
      if (!presetn) begin
         lk_shift_q <= 32'h0000_0000;
         lk_word_q  <= 32'h0000_0000;
         lk_tgl_q   <= 1'b0;
      end else if (!host_csn && lk_cnt_q != `DCR_DG_BITS) begin
         lk_shift_q <= {lk_shift_q[30:0], host_serial_in}; // [RULE15]
         if (lk_cnt_q == `DCR_DG_BITS - 6'h01) begin
            lk_word_q <= {lk_shift_q[30:0], host_serial_in};
            lk_tgl_q  <= ~lk_tgl_q;
         end
      end
   end

   // ------------------------------------------------------------
   // Crossings into pclk
   // ------------------------------------------------------------
   logic tg_s1_q, tg_s2_q, tg_s3_q, tg_seen_q;
   logic rf_s1_q, rf_s2_q, rf_s3_q, ref_lvl_q;
   logic dg_evt;

   // Word held stable for a full datagram, so only the toggle syncs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tg_s1_q   <= 1'b0;
         tg_s2_q   <= 1'b0;
         tg_s3_q   <= 1'b0;
         tg_seen_q <= 1'b0;
         rf_s1_q   <= 1'b0;
         rf_s2_q   <= 1'b0;
         rf_s3_q   <= 1'b0;
         ref_lvl_q <= 1'b0;
      end else begin
         tg_s1_q <= lk_tgl_q;
         tg_s2_q <= tg_s1_q;
         tg_s3_q <= tg_s2_q;
         if (tg_s2_q == tg_s3_q) begin
            tg_seen_q <= tg_s3_q;
         end
         rf_s1_q <= ref_switch;
         rf_s2_q <= rf_s1_q;
         rf_s3_q <= rf_s2_q;
         if (rf_s2_q == rf_s3_q) begin
            ref_lvl_q <= rf_s3_q;
         end
      end
   end
   assign dg_evt = (tg_s2_q == tg_s3_q) && (tg_s3_q != tg_seen_q);

   // Datagram field decode
   logic        dg_mem, dg_rd;
   logic [5:0]  dg_addr;
   logic [31:0] dg_w;
   assign dg_w    = lk_word_q;
   assign dg_mem  = dg_w[`DCR_DG_RRS]; // [RULE7]
   assign dg_rd   = dg_w[`DCR_DG_RW];
   assign dg_addr = dg_w[`DCR_DG_ADDR_HI:`DCR_DG_ADDR_LO]; // [RULE8]

   // ------------------------------------------------------------
   // APB decode
   // ------------------------------------------------------------
   logic apb_wr, apb_rd;
   assign apb_wr = psel && penable && pwrite && pready;
   assign apb_rd = psel && !penable && !pwrite;

   logic hr_wr;
   assign hr_wr = dg_evt && !dg_mem && !dg_rd;

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   logic [3:0]  ctrl_q;
   logic [23:0] switch_ignore_window_q;
   logic [23:0] latched_q;
   logic        armed_q, captured_q;
   logic [1:0]  last_driver_index;
   logic        stop_en, start_req;
   assign last_driver_index = ctrl_q[`DCR_CTRL_LAST_L+1:`DCR_CTRL_LAST_L];
   assign stop_en = ctrl_q[`DCR_CTRL_STOPEN];
   assign start_req = ctrl_q[`DCR_CTRL_START];

   // Control; start bit self-clears after one cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= `DCR_CTRL_RST;
      end else if (apb_wr && paddr == `DCR_OFF_CTRL) begin
         ctrl_q <= pwdata[3:0];
      end else if (hr_wr && dg_addr == `DCR_IDX_CTRL) begin
         ctrl_q <= dg_w[3:0];
      end else begin
         ctrl_q[`DCR_CTRL_START] <= 1'b0;
      end
   end

   // Tolerance window; zero disables the suppression
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         switch_ignore_window_q <= `DCR_WINDOW_RST;
      end else if (apb_wr && paddr == `DCR_OFF_WINDOW) begin
         switch_ignore_window_q <= pwdata[23:0];
      end else if (hr_wr && dg_addr == `DCR_IDX_WINDOW) begin
         switch_ignore_window_q <= dg_w[23:0];
      end
   end

   // Reference edge detect on the filtered level
   logic ref_prev_q, ref_rise;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ref_prev_q <= 1'b0;
      end else begin
         ref_prev_q <= ref_lvl_q;
      end
   end
   assign ref_rise = ref_lvl_q && !ref_prev_q;

   // Position latch; capture beats a same-cycle re-arm
   logic arm_wr;
   assign arm_wr = (apb_wr && paddr == `DCR_OFF_LATCH)
                 || (hr_wr && dg_addr == `DCR_IDX_LATCH);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         latched_q  <= 24'h00_0000;
         armed_q    <= 1'b0;
         captured_q <= 1'b0;
      end else if (armed_q && ref_rise) begin
         latched_q  <= motor_position; // [RULE3]
         armed_q    <= 1'b0;
         captured_q <= 1'b1;
      end else if (arm_wr) begin
         armed_q    <= 1'b1; // [RULE2]
         captured_q <= 1'b0;
      end
   end

   // Automatic stop, lifted inside the tolerance window
   logic in_window;
   assign in_window = (switch_ignore_window_q != 24'h00_0000)
      && (pos_dist(motor_position, latched_q) <= switch_ignore_window_q);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         motor_stop <= 1'b0;
      end else begin
         motor_stop <= stop_en && ref_lvl_q && !in_window; // [RULE4] [RULE1]
      end
   end

   // ------------------------------------------------------------
   // Configuration memory
   // ------------------------------------------------------------
   // Two six-bit cells per address; no reset, contents are software's
   always_ff @(posedge pclk) begin
      if (dg_evt && dg_mem && !dg_rd) begin
         ram_q[{dg_addr, 1'b0}] <= dg_w[5:0]; // [RULE5] [RULE6]
         ram_q[{dg_addr, 1'b1}] <= dg_w[11:6];
      end
   end

   // Last datagram read answer, readable over APB
   logic [31:0] reply_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reply_q <= 32'h0000_0000;
      end else if (dg_evt && dg_rd) begin
         if (dg_mem) begin
            reply_q <= {8'h00, 12'h000, ram_q[{dg_addr, 1'b1}],
                        ram_q[{dg_addr, 1'b0}]}; // [RULE18]
         end else begin
            unique case (dg_addr)
               `DCR_IDX_CTRL:   reply_q <= {28'h000_0000, ctrl_q};
               `DCR_IDX_WINDOW: reply_q <= {8'h00, switch_ignore_window_q};
               `DCR_IDX_LATCH:  reply_q <= {8'h00, latched_q};
               default:         reply_q <= 32'h0000_0000;
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // Driver chain sequencer
   // ------------------------------------------------------------
   dcr_chain_type ch_q;
   logic [5:0]  widx_q;
   logic [1:0]  drv_q;
   logic [3:0]  div_q;
   logic        nxm_q;
   logic [5:0]  cur_w;
   logic [6:0]  wa, wb;
   logic        sig_bit;
   assign cur_w = ram_q[{1'b0, widx_q[5:1], widx_q[0]}]; // [RULE9]
   assign wa = wave(ustep_phase);
   assign wb = wave(ustep_phase + 8'h40); // [RULE14]

   // Signal picked by the five-bit code of the current word
   always_comb begin
      unique case (cur_w[4:0])
         5'h06:           sig_bit = wa[6];
         5'h07, 5'h0F:    sig_bit = 1'b0;
         5'h0E:           sig_bit = wb[6];
         `DCR_CODE_ONE:   sig_bit = 1'b1;
         `DCR_CODE_ZERO:  sig_bit = 1'b0;
         default: begin
            if (cur_w[4:3] == 2'b00) begin
               sig_bit = wa[cur_w[2:0]];
            end else if (cur_w[4:3] == 2'b01) begin
               sig_bit = wb[cur_w[2:0]];
            end else begin
               sig_bit = 1'b0;
            end
         end
      endcase
   end

   // One word per chain clock period, read from the first address on
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ch_q      <= CH_IDLE;
         widx_q    <= 6'h00;
         drv_q     <= 2'b00;
         div_q     <= 4'h0;
         nxm_q     <= 1'b0;
         chain_sck <= 1'b0;
         chain_sdo <= 1'b0;
         chain_csn <= 1'b1;
      end else begin
         unique case (ch_q)
            CH_IDLE: begin
               if (start_req) begin
                  widx_q    <= 6'h00; // [RULE10]
                  chain_csn <= 1'b0;
                  ch_q      <= CH_LOAD;
               end
            end
            CH_LOAD: begin
               chain_sdo <= sig_bit; // [RULE10]
               nxm_q     <= cur_w[5];
               chain_sck <= 1'b0;
               div_q     <= 4'(`DCR_HALF_CYC - 1);
               ch_q      <= CH_LOW;
            end
            CH_LOW: begin
               if (div_q == 4'h0) begin
                  chain_sck <= 1'b1;
                  div_q     <= 4'(`DCR_HALF_CYC - 1);
                  ch_q      <= CH_HIGH;
               end else begin
                  div_q <= div_q - 4'h1;
               end
            end
            CH_HIGH: begin
               if (div_q != 4'h0) begin
                  div_q <= div_q - 4'h1;
               end else begin
                  chain_sck <= 1'b0;
                  widx_q    <= widx_q + 6'h01;
                  ch_q      <= CH_LOAD;
                  if (nxm_q && drv_q == last_driver_index) begin
                     drv_q     <= 2'b00; // [RULE12]
                     chain_csn <= 1'b1;
                     ch_q      <= CH_IDLE;
                  end else if (widx_q == `DCR_LAST_WORD) begin
                     drv_q     <= 2'b00;
                     chain_csn <= 1'b1;
                     ch_q      <= CH_IDLE;
                  end else if (nxm_q) begin
                     drv_q <= drv_q + 2'b01; // [RULE11]
                  end
               end
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // APB slave: zero wait, unmapped reads zero with error
   // ------------------------------------------------------------
   logic mapped;
   assign mapped = paddr == `DCR_OFF_CTRL || paddr == `DCR_OFF_WINDOW
      || paddr == `DCR_OFF_LATCH || paddr == `DCR_OFF_STATUS
      || paddr == `DCR_OFF_REPLY;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !mapped;
         if (apb_rd) begin
            unique case (paddr)
               `DCR_OFF_CTRL:   prdata <= {28'h000_0000, ctrl_q};
               `DCR_OFF_WINDOW: prdata <= {8'h00, switch_ignore_window_q};
               `DCR_OFF_LATCH:  prdata <= {8'h00, latched_q};
               `DCR_OFF_STATUS: prdata <= {27'h000_0000, ref_lvl_q,
                                  !chain_csn, motor_stop, captured_q, armed_q};
               `DCR_OFF_REPLY:  prdata <= reply_q;
               default:         prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_arm_on_write: assert property (arm_wr && !(armed_q && ref_rise) // [RULE2]
      |=> armed_q) else $error("latch not armed");
   a_capture_pos: assert property (armed_q && ref_rise // [RULE3]
      |=> captured_q && latched_q == $past(motor_position))
      else $error("position not captured");
   a_stop_follow: assert property (stop_en && ref_lvl_q && !in_window // [RULE4]
      |=> motor_stop) else $error("stop missing");
   a_window_free: assert property (in_window |=> !motor_stop) // [RULE1]
      else $error("stop inside window");
   a_ram_write: assert property (dg_evt && dg_mem && !dg_rd // [RULE6]
      |=> ram_q[{$past(dg_addr), 1'b1}] == $past(dg_w[11:6]))
      else $error("memory word not stored");
   a_reg_space: assert property (dg_evt && !dg_mem && !dg_rd // [RULE7]
      && dg_addr == `DCR_IDX_WINDOW && !(apb_wr && paddr == `DCR_OFF_WINDOW)
      |=> switch_ignore_window_q == $past(dg_w[23:0]))
      else $error("register write lost");
   a_mem_upper_zero: assert property (dg_evt && dg_rd && dg_mem // [RULE18]
      |=> reply_q[23:12] == 12'h000) else $error("reply upper bits");
   a_chain_start: assert property (ch_q == CH_IDLE && start_req // [RULE10]
      |=> widx_q == 6'h00 && !chain_csn ##1 ch_q == CH_LOW)
      else $error("chain start");
   a_chain_end: assert property (ch_q == CH_HIGH && div_q == 4'h0 && nxm_q // [RULE12]
      && drv_q == last_driver_index |=> chain_csn && drv_q == 2'b00)
      else $error("chain end");
   a_drv_count: assert property (ch_q == CH_HIGH && div_q == 4'h0 && nxm_q // [RULE11]
      && drv_q != last_driver_index && widx_q != `DCR_LAST_WORD
      |=> drv_q == $past(drv_q) + 2'b01) else $error("driver index");

   c_capture: cover property (armed_q && ref_rise);
   c_chain_done: cover property (ch_q == CH_HIGH ##1 ch_q == CH_IDLE);
   c_window_hold: cover property (ref_lvl_q && stop_en && in_window);
endmodule // dcr_chain_latch
`default_nettype wire

/* dcr_cfg.svh */
// Constants of the driver chain RAM and reference latch block.
// Assumes inclusion by bare name from the package and the design.
`ifndef DCR_CFG_SVH
`define DCR_CFG_SVH
// APB byte offsets
`define DCR_OFF_CTRL    8'h00
`define DCR_OFF_WINDOW  8'h04
`define DCR_OFF_LATCH   8'h08
`define DCR_OFF_STATUS  8'h0C
`define DCR_OFF_REPLY   8'h10
// Datagram fields
`define DCR_DG_RRS      31
`define DCR_DG_ADDR_HI  30
`define DCR_DG_ADDR_LO  25
`define DCR_DG_RW       24
`define DCR_DG_BITS     6'h20
// Register space indexes inside datagrams
`define DCR_IDX_CTRL    6'h00
`define DCR_IDX_WINDOW  6'h01
`define DCR_IDX_LATCH   6'h02
// Control field positions
`define DCR_CTRL_STOPEN 0
`define DCR_CTRL_LAST_L 1
`define DCR_CTRL_START  3
// Reset values
`define DCR_CTRL_RST    4'h0
`define DCR_WINDOW_RST  24'h00_0000
// Memory shape
`define DCR_RAM_CELLS   128
`define DCR_LAST_WORD   6'h3F
// Chain clock half period in ns, cycles at 5 ns
`define DCR_HALF_NS     40
`define DCR_CLK_NS      5
`define DCR_HALF_CYC    ((`DCR_HALF_NS + `DCR_CLK_NS - 1) / `DCR_CLK_NS)
// Signal codes of the fixed constants
`define DCR_CODE_ZERO   5'h10
`define DCR_CODE_ONE    5'h11
`endif

/* dcr_pkg.sv */
// Types of the driver chain RAM and reference latch block.
// Assumes dcr_cfg.svh on the include path.
`include "dcr_cfg.svh"
package dcr_pkg;
   typedef enum logic [3:0] {
      CH_IDLE = 4'b0001,
      CH_LOAD = 4'b0010,
      CH_LOW  = 4'b0100,
      CH_HIGH = 4'b1000
   } dcr_chain_type;
endpackage

/* dcr_host_model.sv */
// Host partner: shifts 32-bit datagrams into the link, most significant bit first.
// Assumes the link clock parks low and stands still between frames.
`timescale 1ns/1ps
`default_nettype none
module dcr_host_model (
   output logic host_sck,
   output logic host_csn,
   output logic host_serial_in
);
   // ----------------------------------------
   // Idle link
   // ----------------------------------------
   initial begin
      host_sck       = 1'b0;
      host_csn       = 1'b1;
      host_serial_in = 1'b0;
   end

   // One whole frame, 48 ns period, data moves on the falling edge
   task automatic send(input logic [31:0] dg);
      #3;
      host_csn = 1'b0;
      for (int i = 31; i >= 0; i--) begin
         host_serial_in = dg[i];
         #24 host_sck = 1'b1;
         #24 host_sck = 1'b0;
      end
      #24 host_csn = 1'b1;
      // Released line shows the inverse so a stale bit cannot pass
      host_serial_in = ~host_serial_in;
      #48;
   endtask
endmodule // dcr_host_model
`default_nettype wire

/* tb_top.sv */
// Self-checking bench: APB master, host link partner, chain bit capture.
// Assumes the block answers APB with zero wait states and a 200 MHz pclk.
`timescale 1ns/1ps
`default_nettype none
`include "dcr_cfg.svh"
module tb_top;
   import dcr_pkg::*;
   // ----------------------------------------
   // Signals and model state
   // ----------------------------------------
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr, ustep_phase;
   logic [31:0] pwdata, prdata, rd, seed, d;
   logic        host_sck, host_csn, host_serial_in, ref_switch, er;
   logic [23:0] motor_position, p, p2;
   logic        motor_stop, chain_sck, chain_sdo, chain_csn;
   logic [5:0]  mem [128];
   logic        got_q [$];
   logic        exp_q [$];
   int          error_cnt, compares, n;
   int          addrs [6] = '{0, 1, 5, 31, 32, 63};

   dcr_chain_latch i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .host_sck(host_sck), .host_csn(host_csn),
      .host_serial_in(host_serial_in), .ref_switch(ref_switch),
      .motor_position(motor_position), .ustep_phase(ustep_phase),
      .motor_stop(motor_stop), .chain_sck(chain_sck), .chain_sdo(chain_sdo),
      .chain_csn(chain_csn));
   dcr_host_model i_host (.host_sck(host_sck), .host_csn(host_csn),
      .host_serial_in(host_serial_in));

   // 5 ns system clock
   initial pclk = 1'b0;
   always #2.5 pclk = ~pclk;

   // Chain bits taken on the driver's sampling edge
   always @(posedge chain_sck) begin
      if (chain_csn === 1'b0) got_q.push_back(chain_sdo);
   end

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic final_report;
      $display("compares %0d error_cnt %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic tmo;
      error_cnt++;
      $display("Error at %0t: wait ran out", $time);
      final_report();
   endtask

   // Setup, access until pready, then release
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) tmo();
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // Datagram then a settle gap for the link crossing
   task automatic dg(input logic [31:0] v);
      i_host.send(v);
      repeat (20) @(posedge pclk);
   endtask

   // Walk the chain words as the sequencer should
   function automatic void build_exp(input int last);
      int idx;
      logic [7:0] ph_b;
      idx = 0;
      ph_b = ustep_phase + 8'h40;
      exp_q.delete();
      for (int w = 0; w < 128; w++) begin
         // Sign of wave A follows phase, wave B a quarter period later
         case (mem[w][4:0])
            `DCR_CODE_ONE: exp_q.push_back(1'b1);
            5'h06:         exp_q.push_back(ustep_phase[7]);
            5'h0E:         exp_q.push_back(ph_b[7]);
            default:       exp_q.push_back(1'b0);
         endcase
         if (mem[w][5]) begin
            if (idx == last) break;
            idx++;
         end
      end
   endfunction

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      seed = 32'h13ee_3d5c;
      {presetn, psel, penable, pwrite, paddr, pwdata, ref_switch} = '0;
      motor_position = 24'h00_0000;
      ustep_phase = 8'h00;
      error_cnt = 0;
      compares = 0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      ustep_phase <= $random(seed);
      apb(1'b0, `DCR_OFF_WINDOW, 32'h0000_0000);
      chk(rd, {8'h00, `DCR_WINDOW_RST});
      apb(1'b0, 8'h20, 32'h0000_0000);
      chk({er, rd}, {1'b1, 32'h0000_0000});
      $display("register map test done");
      // Memory writes and read-back through the link, both ranges
      foreach (addrs[k]) begin
         d = $random(seed);
         if (addrs[k] == 0) d[11:0] = 12'hC11;
         if (addrs[k] == 1) d[11:0] = 12'hB86;
         mem[2*addrs[k]]   = d[5:0];
         mem[2*addrs[k]+1] = d[11:6];
         dg({1'b1, 6'(addrs[k]), 1'b0, d[23:0]});
         dg({1'b1, 6'(addrs[k]), 1'b1, 24'h00_0000});
         apb(1'b0, `DCR_OFF_REPLY, 32'h0000_0000);
         chk(rd[23:0], {12'h000, mem[2*addrs[k]+1], mem[2*addrs[k]]});
      end
      $display("memory test done");
      // Two chain runs; the second proves the index restarted at zero
      for (int l = 1; l >= 0; l--) begin
         build_exp(l);
         got_q.delete();
         apb(1'b1, `DCR_OFF_CTRL, {28'h000_0000, 1'b1, 2'(l), 1'b0});
         // Frame select falls one edge after the start write lands
         n = 0;
         while (chain_csn !== 1'b0 && n < 20) begin
            @(posedge pclk);
            n++;
         end
         if (n >= 20) tmo();
         n = 0;
         while (chain_csn !== 1'b1 && n < 3000) begin
            @(posedge pclk);
            n++;
         end
         if (n >= 3000) tmo();
         repeat (2) @(posedge pclk);
         chk(got_q.size(), exp_q.size());
         foreach (exp_q[i]) chk(got_q[i], exp_q[i]);
      end
      $display("chain test done");
      // Reference search: arm, capture, stop, window, re-arm, second edge
      p = ($random(seed) & 24'h0F_FFFF) | 24'h10_0000;
      motor_position <= p;
      apb(1'b1, `DCR_OFF_LATCH, $random(seed));
      apb(1'b0, `DCR_OFF_STATUS, 32'h0000_0000);
      chk(rd[1:0], 2'b01);
      apb(1'b1, `DCR_OFF_CTRL, 32'h0000_0001);
      ref_switch <= 1'b1;
      repeat (12) @(posedge pclk);
      chk(motor_stop, 1'b1);
      apb(1'b0, `DCR_OFF_LATCH, 32'h0000_0000);
      chk(rd, {8'h00, p});
      dg({1'b0, `DCR_IDX_WINDOW, 1'b0, 24'h00_0010});
      apb(1'b0, `DCR_OFF_WINDOW, 32'h0000_0000);
      chk(rd, 32'h0000_0010);
      motor_position <= p + 24'h00_0008;
      repeat (12) @(posedge pclk);
      chk(motor_stop, 1'b0);
      motor_position <= p + 24'h00_0028;
      repeat (12) @(posedge pclk);
      chk(motor_stop, 1'b1);
      ref_switch <= 1'b0;
      p2 = p - 24'h00_0064;
      motor_position <= p2;
      apb(1'b1, `DCR_OFF_LATCH, 32'h0000_0000);
      ref_switch <= 1'b1;
      repeat (12) @(posedge pclk);
      apb(1'b0, `DCR_OFF_LATCH, 32'h0000_0000);
      chk(rd, {8'h00, p2});
      // Host moves to the midpoint of both edges; the position keeps its midpoint value
      motor_position <= 24'((p + p2) / 2);
      $display("reference test done");
      final_report();
   end
endmodule // tb_top
`default_nettype wire
